// ### shared/ald_regs.svh
`ifndef ALD_REGS_SVH
`define ALD_REGS_SVH
// ***********************************************
// device register offsets
// ***********************************************
`define ALD_UPPER_LO 12'h247
`define ALD_UPPER_HI 12'h248
`define ALD_LOWER_LO 12'h249
`define ALD_LOWER_HI 12'h24a
`define ALD_DWELL_LO 12'h24b
`define ALD_DWELL_HI 12'h24c
`define ALD_MON_CTRL 12'h270
`define ALD_PERIOD_0 12'h271
`define ALD_PERIOD_1 12'h272
`define ALD_PERIOD_2 12'h273
`define ALD_HOLD_LO 12'h274
`define ALD_HOLD_HI 12'h275
`define ALD_SER_A 12'h279
`define ALD_SER_B 12'h27a
`define ALD_OUT_CTRL_A 12'h559
`define ALD_OUT_CTRL_B 12'h55a
`define ALD_OR_CLEAR 12'h562
`define ALD_OR_STICKY 12'h563
`define ALD_CB_SOURCE 12'h58f
// ***********************************************
// fields and timing
// ***********************************************
`define ALD_MON_EN_BIT 1
`define ALD_FD_EN_BIT 0
`define ALD_SIDEBAND_STATUS_PORT_EN_BIT 0
`define ALD_SER_B_BIT 1
`define ALD_RESET_BYTE 8'h00
`define ALD_LOWER_PIPE 4
`define ALD_FRAME_BITS 25
// ***********************************************
// receiver axi offsets
// ***********************************************
`define ALD_RX_STATUS 4'h0
`define ALD_RX_PEAK 4'h4
`define ALD_RX_CMD 4'h8
`define ALD_RX_RDATA 4'hc
`define ALD_RX_CMD_READ_BIT 24
`define ALD_AXI_OKAY 2'b00
`define ALD_AXI_SLVERR 2'b10
`endif

// ### shared/ald_pkg.sv
package ald_pkg;
   typedef logic [12:0] ald_mag_t;
   typedef enum logic [1:0] {ALD_RX_IDLE = 2'b00, ALD_RX_COLLECT = 2'b01} ald_rx_e;
endpackage : ald_pkg

// ### shared/ald_link_if.sv
`timescale 1ns/1ns
`default_nettype none
interface ald_link_if;
   logic [13:0] smp_data;
   logic [2:0] smp_ctrl;
   logic smp_valid;
   logic fast_threshold_flag;
   logic cfg_wr;
   logic cfg_rd;
   logic [11:0] cfg_addr;
   logic [7:0] cfg_wdata;
   logic [7:0] cfg_rdata;
   logic cfg_rvalid;
   modport dev (output smp_data, smp_ctrl, smp_valid, fast_threshold_flag, cfg_rdata, cfg_rvalid,
                input cfg_wr, cfg_rd, cfg_addr, cfg_wdata);
   modport rcv (input smp_data, smp_ctrl, smp_valid, fast_threshold_flag, cfg_rdata, cfg_rvalid,
                output cfg_wr, cfg_rd, cfg_addr, cfg_wdata);
endinterface : ald_link_if
`default_nettype wire

// ### rtl/ald_delay.sv
`timescale 1ns/1ns
`default_nettype none
`include "ald_regs.svh"
module ald_delay #(
   parameter int W = 13,
   parameter int DEPTH = `ALD_LOWER_PIPE
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // stream
   input wire logic in_valid,
   input wire logic [W-1:0] in_data,
   output logic [W-1:0] out_data
);
   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] pipe;
   } ald_dly_s;
   ald_dly_s st, next_st;

   always_comb
   begin
      next_st = st;
      if (in_valid)
      begin
         next_st.pipe = {st.pipe[DEPTH-2:0], in_data};
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         st <= '0;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign out_data = st.pipe[DEPTH-1];
endmodule : ald_delay
`default_nettype wire

// ### rtl/ald_device.sv
`timescale 1ns/1ns
`default_nettype none
`include "ald_regs.svh"
// Operation
// - sticky overrange bit per virtual converter
// - clear bit toggled high then low
// - flag sets when magnitude exceeds upper
// - flag clears after dwell below lower
// - upper detection reaches flag within 28
// - upper threshold pair vs output magnitude
// - lower threshold 13 bits, two registers
// - lower compare after pipeline delay
// - dwell 16-bit count, two registers
// - fast threshold gated by output control
// - monitor tracks magnitude, 13-bit peak
// - global 24-bit period in samples
// - period programmed before monitor enable
// - enable loads countdown, decrements per sample
// - peak seeded then keeps larger magnitude
// - count of 1 copies peak to holding
// - reload timer, reseed peak next sample
// - serial monitor needs both enable registers
// - up to three control bits, MSB first
// - 25-bit frame, five start-led subframes
// - sideband option needs five registers
// - embedded overrange matches sample latency
module ald_device #(
   parameter int LOWER_PIPE = `ALD_LOWER_PIPE
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // converter samples
   input wire logic sample_valid,
   input wire logic [13:0] sample_in,
   input wire logic [3:0] overrange_in,
   // link to receiver
   ald_link_if.dev link
);
   typedef struct packed {
      logic [7:0] upper_lo;
      logic [7:0] upper_hi;
      logic [7:0] lower_lo;
      logic [7:0] lower_hi;
      logic [7:0] dwell_lo;
      logic [7:0] dwell_hi;
      logic [7:0] mon_ctrl;
      logic [23:0] period;
      logic [7:0] ser_a;
      logic [7:0] ser_b;
      logic [7:0] oc_a;
      logic [7:0] oc_b;
      logic [7:0] or_clr;
      logic [3:0] or_sticky;
      logic [7:0] cb_src;
      ald_pkg::ald_mag_t hold;
      ald_pkg::ald_mag_t peak;
      logic [23:0] timer;
      logic mon_run;
      logic reseed;
      logic [15:0] dwell_cnt;
      logic flag;
      logic [24:0] frame;
      logic [4:0] frame_left;
      logic [13:0] smp_data;
      logic [2:0] smp_ctrl;
      logic smp_valid;
      logic [7:0] rdata;
      logic rvalid;
   } ald_dev_s;
   ald_dev_s st, next_st;

   // ***********************************************
   // helpers
   // ***********************************************
   // two's complement magnitude, saturated to 13 bits (full scale is 2^13)
   function automatic ald_pkg::ald_mag_t mag_of(input logic [13:0] s);
      logic [13:0] a;
      a = s[13] ? 14'(~s + 14'h0001) : s;
      mag_of = (a[13]) ? 13'h1fff : a[12:0];
   endfunction : mag_of

   function automatic ald_pkg::ald_mag_t max_of(input ald_pkg::ald_mag_t a, input ald_pkg::ald_mag_t b);
      max_of = (a > b) ? a : b;
   endfunction : max_of

   function automatic logic [7:0] read_reg(input ald_dev_s s, input logic [11:0] a);
      case (a)
         `ALD_UPPER_LO: read_reg = s.upper_lo;
         `ALD_UPPER_HI: read_reg = s.upper_hi;
         `ALD_LOWER_LO: read_reg = s.lower_lo;
         `ALD_LOWER_HI: read_reg = s.lower_hi;
         `ALD_DWELL_LO: read_reg = s.dwell_lo;
         `ALD_DWELL_HI: read_reg = s.dwell_hi;
         `ALD_MON_CTRL: read_reg = s.mon_ctrl;
         `ALD_PERIOD_0: read_reg = s.period[7:0];
         `ALD_PERIOD_1: read_reg = s.period[15:8];
         `ALD_PERIOD_2: read_reg = s.period[23:16];
         `ALD_HOLD_LO: read_reg = s.hold[7:0];
         `ALD_HOLD_HI: read_reg = {3'h0, s.hold[12:8]};
         `ALD_SER_A: read_reg = s.ser_a;
         `ALD_SER_B: read_reg = s.ser_b;
         `ALD_OUT_CTRL_A: read_reg = s.oc_a;
         `ALD_OUT_CTRL_B: read_reg = s.oc_b;
         `ALD_OR_CLEAR: read_reg = s.or_clr;
         `ALD_OR_STICKY: read_reg = {4'h0, s.or_sticky};
         `ALD_CB_SOURCE: read_reg = s.cb_src;
         default: read_reg = `ALD_RESET_BYTE;
      endcase
   endfunction : read_reg

   // ***********************************************
   // datapath
   // ***********************************************
   ald_pkg::ald_mag_t mag;
   ald_pkg::ald_mag_t mag_late;
   ald_pkg::ald_mag_t upper;
   ald_pkg::ald_mag_t lower;
   logic [15:0] dwell;
   logic fd_en;
   logic sideband_status_port_en;
   logic [1:0] cb_count;
   logic wr;
   logic [3:0] clr_fall;
   ald_pkg::ald_mag_t peak_now;

   assign mag = mag_of(sample_in);
   assign upper = {st.upper_hi[4:0], st.upper_lo};
   assign lower = {st.lower_hi[4:0], st.lower_lo};
   assign dwell = {st.dwell_hi, st.dwell_lo};
   assign fd_en = st.oc_a[`ALD_FD_EN_BIT] & st.oc_b[`ALD_FD_EN_BIT];
   assign cb_count = st.cb_src[1:0];
   // the serial frame only leaves the part when all five selection registers agree (ser_a, ser_b, oc_a, oc_b, cb_src)
   assign sideband_status_port_en = (st.ser_a[1:0] == 2'b11) & st.ser_b[`ALD_SER_B_BIT]
      & st.oc_a[`ALD_SIDEBAND_STATUS_PORT_EN_BIT] & st.oc_b[`ALD_SIDEBAND_STATUS_PORT_EN_BIT] & (cb_count != 2'b00);
   assign wr = link.cfg_wr;
   assign peak_now = st.reseed ? mag : max_of(st.peak, mag);

   // lower compare looks at the magnitude after the converter pipeline
   ald_delay #(
      .W(13),
      .DEPTH(LOWER_PIPE)
   ) u_lower_pipe (
      .aclk(aclk),
      .aresetn(aresetn),
      .in_valid(sample_valid),
      .in_data(mag),
      .out_data(mag_late)
   );

   always_comb
   begin
      next_st = st;
      clr_fall = 4'h0;
      // configuration writes
      if (wr)
      begin
         case (link.cfg_addr)
            `ALD_UPPER_LO: next_st.upper_lo = link.cfg_wdata;
            `ALD_UPPER_HI: next_st.upper_hi = link.cfg_wdata;
            `ALD_LOWER_LO: next_st.lower_lo = link.cfg_wdata;
            `ALD_LOWER_HI: next_st.lower_hi = link.cfg_wdata;
            `ALD_DWELL_LO: next_st.dwell_lo = link.cfg_wdata;
            `ALD_DWELL_HI: next_st.dwell_hi = link.cfg_wdata;
            `ALD_MON_CTRL: next_st.mon_ctrl = link.cfg_wdata;
            `ALD_PERIOD_0: next_st.period[7:0] = link.cfg_wdata;
            `ALD_PERIOD_1: next_st.period[15:8] = link.cfg_wdata;
            `ALD_PERIOD_2: next_st.period[23:16] = link.cfg_wdata;
            `ALD_SER_A: next_st.ser_a = link.cfg_wdata;
            `ALD_SER_B: next_st.ser_b = link.cfg_wdata;
            `ALD_OUT_CTRL_A: next_st.oc_a = link.cfg_wdata;
            `ALD_OUT_CTRL_B: next_st.oc_b = link.cfg_wdata;
            `ALD_OR_CLEAR:
            begin
               next_st.or_clr = link.cfg_wdata;
               clr_fall = st.or_clr[3:0] & ~link.cfg_wdata[3:0];
            end
            `ALD_CB_SOURCE: next_st.cb_src = link.cfg_wdata;
            default: next_st.rdata = next_st.rdata;
         endcase
      end
      next_st.rvalid = link.cfg_rd;
      if (link.cfg_rd)
      begin
         next_st.rdata = read_reg(st, link.cfg_addr);
      end
      // overrange sticky: a new event in the clearing cycle survives
      next_st.or_sticky = (st.or_sticky & ~clr_fall) | (sample_valid ? overrange_in : 4'h0);
      // peak monitor; a period write after enable is only seen at the next reload
      if (!st.mon_ctrl[`ALD_MON_EN_BIT])
      begin
         next_st.mon_run = 1'b0;
      end
      else if (!st.mon_run)
      begin
         next_st.mon_run = 1'b1;
         next_st.timer = st.period;
         next_st.reseed = 1'b1;
      end
      else if (sample_valid)
      begin
         if (st.timer <= 24'h00_0001)
         begin
            next_st.hold = peak_now;
            next_st.timer = st.period;
            next_st.reseed = 1'b1;
            if (sideband_status_port_en)
            begin
               next_st.frame = {1'b1, 4'h0, 1'b1, 3'h0, peak_now[12], 1'b1,
                                peak_now[11:8], 1'b1, peak_now[7:4], 1'b1, peak_now[3:0]};
               next_st.frame_left = 5'(`ALD_FRAME_BITS);
            end
         end
         else
         begin
            next_st.timer = st.timer - 24'h00_0001;
            next_st.peak = peak_now;
            next_st.reseed = 1'b0;
         end
      end
      // fast threshold flag with dwell release
      if (!fd_en)
      begin
         next_st.flag = 1'b0;
         next_st.dwell_cnt = 16'h0000;
      end
      else if (sample_valid)
      begin
         if (mag > upper)
         begin
            next_st.flag = 1'b1;
            next_st.dwell_cnt = 16'h0000;
         end
         else if (st.flag && (mag_late < lower))
         begin
            next_st.dwell_cnt = st.dwell_cnt + 16'h0001;
            if (st.dwell_cnt >= dwell)
            begin
               next_st.flag = 1'b0;
               next_st.dwell_cnt = 16'h0000;
            end
         end
         else
         begin
            next_st.dwell_cnt = 16'h0000;
         end
      end
      // output samples with control bits appended, one register stage for all
      next_st.smp_valid = sample_valid;
      if (sample_valid)
      begin
         next_st.smp_data = sample_in;
         next_st.smp_ctrl[2] = (st.frame_left != 5'h00) ? st.frame[24] : |overrange_in;
         next_st.smp_ctrl[1] = (cb_count >= 2'd2) & (|overrange_in);
         next_st.smp_ctrl[0] = (cb_count == 2'd3) & st.flag;
         if (cb_count == 2'd0)
         begin
            next_st.smp_ctrl[2] = 1'b0;
         end
         if (st.frame_left != 5'h00)
         begin
            next_st.frame = {st.frame[23:0], 1'b0};
            next_st.frame_left = st.frame_left - 5'h01;
         end
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         st <= '0;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign link.smp_data = st.smp_data;
   assign link.smp_ctrl = st.smp_ctrl;
   assign link.smp_valid = st.smp_valid;
   assign link.fast_threshold_flag = st.flag;
   assign link.cfg_rdata = st.rdata;
   assign link.cfg_rvalid = st.rvalid;
endmodule : ald_device
`default_nettype wire

// ### rtl/ald_receiver.sv
`timescale 1ns/1ns
`default_nettype none
`include "ald_regs.svh"
module ald_receiver (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite slave
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // link to device
   ald_link_if.rcv link
);
   typedef struct packed {
      ald_pkg::ald_rx_e state;
      logic [24:0] shift;
      logic [4:0] count;
      ald_pkg::ald_mag_t peak;
      logic frame_err;
      logic peak_new;
      logic aw_have;
      logic [3:0] aw_addr;
      logic w_have;
      logic [31:0] w_data;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic cfg_wr;
      logic cfg_rd;
      logic [11:0] cfg_addr;
      logic [7:0] cfg_wdata;
      logic [7:0] cfg_rdata;
      logic cfg_done;
   } ald_rx_s;
   ald_rx_s st, next_st;
   logic [24:0] shifted;
   logic [31:0] wd;

   // start bits sit at the head of every 5-bit subframe
   function automatic logic starts_ok(input logic [24:0] f);
      starts_ok = f[24] & f[19] & f[14] & f[9] & f[4];
   endfunction : starts_ok

   always_comb
   begin
      next_st = st;
      shifted = {st.shift[23:0], link.smp_ctrl[2]};
      wd = st.w_data;
      next_st.cfg_wr = 1'b0;
      next_st.cfg_rd = 1'b0;
      // ***********************************************
      // frame deserializer
      // ***********************************************
      // between frames bit 2 carries the overrange OR; any one seen here is taken as a frame's first start bit
      if (link.smp_valid)
      begin
         case (st.state)
            ald_pkg::ALD_RX_IDLE:
            begin
               if (link.smp_ctrl[2])
               begin
                  next_st.shift = 25'h000_0001;
                  next_st.count = 5'h01;
                  next_st.state = ald_pkg::ALD_RX_COLLECT;
               end
            end
            ald_pkg::ALD_RX_COLLECT:
            begin
               next_st.shift = shifted;
               next_st.count = st.count + 5'h01;
               if (st.count == 5'(`ALD_FRAME_BITS - 1))
               begin
                  next_st.state = ald_pkg::ALD_RX_IDLE;
                  if (starts_ok(shifted))
                  begin
                     next_st.peak = {shifted[15], shifted[13:10], shifted[8:5], shifted[3:0]};
                     next_st.peak_new = 1'b1;
                  end
                  else
                  begin
                     next_st.frame_err = 1'b1;
                  end
               end
            end
            default: next_st.state = ald_pkg::ALD_RX_IDLE;
         endcase
      end
      if (link.cfg_rvalid)
      begin
         next_st.cfg_rdata = link.cfg_rdata;
         next_st.cfg_done = 1'b1;
      end
      // ***********************************************
      // axi4-lite slave
      // ***********************************************
      if (s_axi_awvalid && !st.aw_have && !st.bvalid)
      begin
         next_st.aw_have = 1'b1;
         next_st.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !st.w_have && !st.bvalid)
      begin
         next_st.w_have = 1'b1;
         next_st.w_data = s_axi_wdata;
      end
      if (st.aw_have && st.w_have)
      begin
         next_st.aw_have = 1'b0;
         next_st.w_have = 1'b0;
         next_st.bvalid = 1'b1;
         next_st.bresp = `ALD_AXI_OKAY;
         case (st.aw_addr)
            `ALD_RX_STATUS:
            begin
               // write one to clear; a new event in the same cycle wins
               if (wd[1] && !(next_st.frame_err && !st.frame_err))
               begin
                  next_st.frame_err = 1'b0;
               end
               if (wd[2] && !(next_st.peak_new && !st.peak_new))
               begin
                  next_st.peak_new = 1'b0;
               end
            end
            `ALD_RX_CMD:
            begin
               next_st.cfg_addr = wd[19:8];
               next_st.cfg_wdata = wd[7:0];
               next_st.cfg_wr = !wd[`ALD_RX_CMD_READ_BIT];
               next_st.cfg_rd = wd[`ALD_RX_CMD_READ_BIT];
               next_st.cfg_done = 1'b0;
            end
            default: next_st.bresp = `ALD_AXI_SLVERR;
         endcase
      end
      if (st.bvalid && s_axi_bready)
      begin
         next_st.bvalid = 1'b0;
      end
      if (s_axi_arvalid && !st.rvalid)
      begin
         next_st.rvalid = 1'b1;
         next_st.rresp = `ALD_AXI_OKAY;
         case (s_axi_araddr)
            `ALD_RX_STATUS: next_st.rdata = {29'h0, st.peak_new, st.frame_err, link.fast_threshold_flag};
            `ALD_RX_PEAK: next_st.rdata = {19'h0, st.peak};
            `ALD_RX_CMD: next_st.rdata = {12'h0, st.cfg_addr, st.cfg_wdata};
            `ALD_RX_RDATA: next_st.rdata = {23'h0, st.cfg_done, st.cfg_rdata};
            default:
            begin
               next_st.rdata = 32'h0000_0000;
               next_st.rresp = `ALD_AXI_SLVERR;
            end
         endcase
      end
      if (st.rvalid && s_axi_rready)
      begin
         next_st.rvalid = 1'b0;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         st <= '0;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign s_axi_awready = !st.aw_have && !st.bvalid;
   assign s_axi_wready = !st.w_have && !st.bvalid;
   assign s_axi_bvalid = st.bvalid;
   assign s_axi_bresp = st.bresp;
   assign s_axi_arready = !st.rvalid;
   assign s_axi_rvalid = st.rvalid;
   assign s_axi_rdata = st.rdata;
   assign s_axi_rresp = st.rresp;
   assign link.cfg_wr = st.cfg_wr;
   assign link.cfg_rd = st.cfg_rd;
   assign link.cfg_addr = st.cfg_addr;
   assign link.cfg_wdata = st.cfg_wdata;
endmodule : ald_receiver
`default_nettype wire

// ### tb/ald_link_monitor.sv
`timescale 1ns/1ns
`default_nettype none
`include "ald_regs.svh"
// ****
// link checker
// ****
module ald_link_monitor (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // link signals
   input wire logic [13:0] smp_data,
   input wire logic [2:0] smp_ctrl,
   input wire logic smp_valid,
   input wire logic fast_threshold_flag,
   input wire logic cfg_wr,
   input wire logic cfg_rd,
   input wire logic [11:0] cfg_addr,
   input wire logic [7:0] cfg_wdata,
   input wire logic [7:0] cfg_rdata,
   input wire logic cfg_rvalid
);
   // shadow of the settings, rebuilt from writes since the device has no readable state here
   typedef struct packed {logic [7:0] ul, uh, oa, ob, cs;} ald_shadow_s;
   ald_shadow_s st, next_st;
   logic [13:0] mag;
   logic en, above;
   assign mag = smp_data[13] ? ~smp_data + 14'h0001 : smp_data;
   assign en = st.oa[0] & st.ob[0];
   assign above = mag > {1'b0, st.uh[4:0], st.ul};
   always_comb
   begin
      next_st = st;
      if (cfg_wr && cfg_addr == `ALD_UPPER_LO) next_st.ul = cfg_wdata;
      if (cfg_wr && cfg_addr == `ALD_UPPER_HI) next_st.uh = cfg_wdata;
      if (cfg_wr && cfg_addr == `ALD_OUT_CTRL_A) next_st.oa = cfg_wdata;
      if (cfg_wr && cfg_addr == `ALD_OUT_CTRL_B) next_st.ob = cfg_wdata;
      if (cfg_wr && cfg_addr == `ALD_CB_SOURCE) next_st.cs = cfg_wdata;
   end
   always_ff @(posedge aclk) st <= aresetn ? next_st : '0;
   default clocking ald_clk @(posedge aclk); endclocking
   default disable iff (!aresetn);
   AST_FLAG_SET: assert property (smp_valid && above && en |-> fast_threshold_flag)
      else $error("flag low on sample above upper");
   AST_FLAG_LAT: assert property ($rose(smp_valid && above && en) |-> ##[0:27] fast_threshold_flag)
      else $error("flag late");
   AST_FLAG_CAUSE: assert property ($rose(fast_threshold_flag) |-> smp_valid && above)
      else $error("flag rose without cause");
   AST_FLAG_GATE: assert property (!en && $past(!en) |-> !fast_threshold_flag)
      else $error("flag while disabled");
   AST_FLAG_FALL: assert property ($fell(fast_threshold_flag) && en && $past(en) |-> smp_valid && !above)
      else $error("flag fell off sample");
   AST_FLAG_HOLD: assert property (en && $past(en) && !smp_valid |-> $stable(fast_threshold_flag))
      else $error("flag moved between samples");
   AST_RD_ANSWER: assert property (cfg_rd |=> cfg_rvalid)
      else $error("read not answered");
   AST_RV_CAUSE: assert property (cfg_rvalid |-> $past(cfg_rd))
      else $error("answer without read");
   AST_CB_ONE: assert property (smp_valid && st.cs[1:0] == 2'b01 |-> smp_ctrl[1:0] == 2'b00)
      else $error("lower control bits used");
   cover property ($rose(fast_threshold_flag));
   cover property ($fell(fast_threshold_flag));
   cover property (smp_valid && st.cs[1:0] == 2'b01);
endmodule : ald_link_monitor
`default_nettype wire

// ### tb/adc_level_detect_monitor_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "ald_regs.svh"
module adc_level_detect_monitor_tb;
   logic aclk = 0, aresetn = 0, sample_valid = 0;
   logic [13:0] sample_in = '0;
   logic [3:0] overrange_in = '0, s_axi_awaddr = '0, s_axi_araddr = '0, s_axi_wstrb = 4'hf;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata, v;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   int n_mismatch = 0, checks = 0, cyc = 0;
   // rows: device address, written byte, byte read back
   logic [27:0] rows [11] = '{28'h247_abab, 28'h248_1f1f, 28'h249_cdcd, 28'h24a_1a1a, 28'h24b_3434,
      28'h24c_1212, 28'h271_7878, 28'h272_5656, 28'h273_3434, 28'h563_ff00, 28'h100_5a00};
   ald_link_if link ();
   ald_device ald_device_i (.aclk, .aresetn, .sample_valid, .sample_in, .overrange_in, .link(link));
   ald_receiver ald_receiver_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .link(link));
   ald_link_monitor ald_link_monitor_i (.aclk, .aresetn, .smp_data(link.smp_data), .smp_ctrl(link.smp_ctrl),
      .smp_valid(link.smp_valid), .fast_threshold_flag(link.fast_threshold_flag), .cfg_wr(link.cfg_wr),
      .cfg_rd(link.cfg_rd), .cfg_addr(link.cfg_addr), .cfg_wdata(link.cfg_wdata), .cfg_rdata(link.cfg_rdata),
      .cfg_rvalid(link.cfg_rvalid));
   initial
   begin
      forever #10 aclk = ~aclk;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic close_out();
      $display("mismatches %0d checks %0d", n_mismatch, checks);
      if (n_mismatch == 0 && checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : close_out
   // address and data go out together; each is dropped at its own handshake
   task automatic axw(input logic [3:0] a, input logic [31:0] d);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end
      while (!s_axi_bvalid);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : axw
   task automatic axr(input logic [3:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end
      while (!s_axi_rvalid);
      v = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : axr
   task automatic cw(input logic [11:0] a, input logic [7:0] d);
      axw(`ALD_RX_CMD, {7'h00, 1'b0, 4'h0, a, d});
   endtask : cw
   task automatic cr(input logic [11:0] a);
      axw(`ALD_RX_CMD, {7'h00, 1'b1, 4'h0, a, 8'h00});
      do axr(`ALD_RX_RDATA);
      while (v[8] !== 1'b1);
   endtask : cr
   task automatic smp(input logic [13:0] d, input logic [3:0] o);
      @(posedge aclk);
      sample_valid <= 1'b1;
      sample_in <= d;
      overrange_in <= o;
      @(posedge aclk);
      sample_valid <= 1'b0;
   endtask : smp
   task automatic fchk(input logic e);
      @(negedge aclk);
      chk(link.fast_threshold_flag, e);
   endtask : fchk
   always @(posedge aclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         n_mismatch++;
         close_out();
      end
   end
   initial
   begin
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(negedge aclk);
      chk({s_axi_awready, s_axi_wready, s_axi_arready, s_axi_bvalid, link.fast_threshold_flag}, 5'h1c);
      foreach (rows[i])
      begin
         cw(rows[i][27:16], rows[i][15:8]);
         cr(rows[i][27:16]);
         chk(v[7:0], rows[i][7:0]);
      end
      cw(`ALD_UPPER_LO, 8'h00);
      cw(`ALD_UPPER_HI, 8'h01);
      cw(`ALD_LOWER_LO, 8'h80);
      cw(`ALD_LOWER_HI, 8'h00);
      cw(`ALD_DWELL_LO, 8'h02);
      cw(`ALD_DWELL_HI, 8'h00);
      smp(14'h0200, 4'h0);
      fchk(1'b0);
      repeat (12) smp(14'h0010, 4'h0);
      cw(`ALD_OUT_CTRL_A, 8'h01);
      cw(`ALD_OUT_CTRL_B, 8'h01);
      smp(14'h0100, 4'h0);
      fchk(1'b0);
      smp(14'h3eff, 4'h0);
      fchk(1'b1);
      repeat (12) smp(14'h00c0, 4'h0);
      fchk(1'b1);
      repeat (3) smp(14'h0010, 4'h0);
      fchk(1'b1);
      repeat (9) smp(14'h0010, 4'h0);
      fchk(1'b0);
      smp(14'h0055, 4'h5);
      @(negedge aclk);
      chk({link.smp_valid, link.smp_data, link.smp_ctrl}, {1'b1, 14'h0055, 3'h0});
      cr(`ALD_OR_STICKY);
      chk(v[7:0], 8'h05);
      cw(`ALD_OR_CLEAR, 8'h01);
      cr(`ALD_OR_STICKY);
      chk(v[7:0], 8'h05);
      cw(`ALD_OR_CLEAR, 8'h00);
      cr(`ALD_OR_STICKY);
      chk(v[7:0], 8'h04);
      cw(`ALD_SER_A, 8'h03);
      cw(`ALD_SER_B, 8'h02);
      cw(`ALD_CB_SOURCE, 8'h01);
      cw(`ALD_PERIOD_0, 8'h28);
      cw(`ALD_PERIOD_1, 8'h00);
      cw(`ALD_PERIOD_2, 8'h00);
      cw(`ALD_MON_CTRL, 8'h02);
      for (int i = 0; i < 70; i++)
         smp(i == 20 ? 14'h2c01 : 14'h0010, 4'h0);
      axr(`ALD_RX_PEAK);
      chk(v, 32'h0000_13ff);
      chk(r, `ALD_AXI_OKAY);
      cr(`ALD_HOLD_LO);
      chk(v[7:0], 8'hff);
      cr(`ALD_HOLD_HI);
      chk(v[7:0], 8'h13);
      axr(`ALD_RX_STATUS);
      chk(v[2:1], 2'b10);
      axw(`ALD_RX_PEAK, 32'h0000_0000);
      chk(r, `ALD_AXI_SLVERR);
      close_out();
   end
endmodule : adc_level_detect_monitor_tb
`default_nettype wire
